// file: shared/pclrc_pkg.sv
`default_nettype none
package pclrc_pkg;
  // register bus geometry and sequencer counter width
  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 8;
  localparam int LEVEL_W = 4;
  localparam int CNT_W   = 21;

  // register offsets
  localparam logic [ADDR_W-1:0] ADR_DET_CTRL  = 3'h0;
  localparam logic [ADDR_W-1:0] ADR_DET_LEVEL = 3'h1;
  localparam logic [ADDR_W-1:0] ADR_CAUSE     = 3'h2;
  localparam logic [ADDR_W-1:0] ADR_IRQ_STAT  = 3'h3;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK  = 3'h4;

  // field positions
  localparam int CTL_EN_BIT    = 7;
  localparam int CTL_SRC_BIT   = 2;
  localparam int CTL_ACT_BIT   = 1;
  localparam int CTL_FLAG_BIT  = 0;
  localparam int CAUSE_DET_BIT = 0;
  localparam int CAUSE_WDT_BIT = 4;
  localparam int IRQ_CROSS_BIT = 0;
  localparam int IRQ_DRST_BIT  = 1;

  // reset values
  localparam logic [DATA_W-1:0]  CAUSE_RST = 8'h00;
  localparam logic [DATA_W-1:0]  MASK_RST  = 8'h00;
  localparam logic [DATA_W-1:0]  STAT_RST  = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h0;
  localparam logic [DATA_W-1:0]  READ_ZERO = 8'h00;

  // timing: fast-rise window and stabilization wait
  localparam int CLK_MHZ      = 250;
  localparam int POC_FAST_NS  = 1930000;
  localparam int POC_STAB_NS  = 5390000;
  localparam int POC_FAST_CYC = POC_FAST_NS * CLK_MHZ / 1000;
  localparam int POC_STAB_CYC = POC_STAB_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    POC_HOLD      = 2'b00,
    POC_WAIT_HIGH = 2'b01,
    POC_STAB      = 2'b10,
    POC_RUN       = 2'b11
  } pclrc_poc_t;
endpackage
`default_nettype wire

// file: shared/pclrc_cmp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pclrc_cmp_if;
  logic poc_above_low;
  logic poc_above_high;
  logic det_below;
  logic opt_high;
  modport src (output poc_above_low, poc_above_high, det_below, opt_high);
  modport dst (input  poc_above_low, poc_above_high, det_below, opt_high);
endinterface
`default_nettype wire

// file: rtl/pclrc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pclrc_sync (
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  input  wire logic     ce,
  input  wire logic     poc_low_raw,
  input  wire logic     poc_high_raw,
  input  wire logic     det_below_raw,
  input  wire logic     opt_raw,
  pclrc_cmp_if.src      cmp
);
  import pclrc_pkg::*;

  logic [3:0] meta_q;
  logic [3:0] sync_q;

  // two flops per comparator level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else if (ce) begin
      meta_q <= {opt_raw, det_below_raw, poc_high_raw, poc_low_raw};
      sync_q <= meta_q;
    end
  end

  assign cmp.poc_above_low  = sync_q[0];
  assign cmp.poc_above_high = sync_q[1];
  assign cmp.det_below      = sync_q[2];
  assign cmp.opt_high       = sync_q[3];

  property p_sync_delay;
    @(posedge core_clk) disable iff (!rst_n)
    ce ##1 ce |-> sync_q == $past(meta_q);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser second stage did not follow first");
endmodule
`default_nettype wire

// file: rtl/pclrc_poc_seq.sv
`timescale 1ns/10ps
`default_nettype none
module pclrc_poc_seq #(
  parameter int unsigned FAST_CYC = pclrc_pkg::POC_FAST_CYC,
  parameter int unsigned STAB_CYC = pclrc_pkg::POC_STAB_CYC
) (
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  input  wire logic     ce,
  pclrc_cmp_if.dst      cmp,
  output logic          hold,
  output logic          poc_clear_q
);
  import pclrc_pkg::*;

  localparam logic [CNT_W-1:0] FAST_W = CNT_W'(FAST_CYC);
  localparam logic [CNT_W-1:0] STAB_W = CNT_W'(STAB_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  pclrc_poc_t       state_q;
  logic [CNT_W-1:0] cnt_q;

  // release sequencing after power-on or a drop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= POC_HOLD;
      cnt_q   <= '0;
    end else if (ce) begin
      if (!cmp.poc_above_low && state_q != POC_HOLD) begin
        state_q <= POC_HOLD;
      end else begin
        case (state_q)
          POC_HOLD: begin
            cnt_q <= '0;
            if (cmp.poc_above_low) begin
              if (cmp.opt_high) begin
                state_q <= POC_WAIT_HIGH;
              end else begin
                state_q <= POC_RUN;
              end
            end
          end
          POC_WAIT_HIGH: begin
            if (cnt_q != CNT_MAX) begin
              cnt_q <= cnt_q + 1'b1;
            end
            if (cmp.poc_above_high) begin
              cnt_q <= '0;
              if (cnt_q < FAST_W) begin
                state_q <= POC_STAB;
              end else begin
                state_q <= POC_RUN;
              end
            end
          end
          POC_STAB: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q >= STAB_W) begin
              state_q <= POC_RUN;
            end
          end
          POC_RUN:  state_q <= POC_RUN;
          default:  state_q <= POC_HOLD;
        endcase
      end
    end
  end

  // one pulse when the supervisor pulls reset again
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      poc_clear_q <= 1'b0;
    end else if (ce) begin
      poc_clear_q <= !cmp.poc_above_low && state_q != POC_HOLD;
    end
  end

  assign hold = (state_q != POC_RUN);

  property p_low_release;
    @(posedge core_clk) disable iff (!rst_n)
    ce && state_q == POC_HOLD && cmp.poc_above_low && !cmp.opt_high
    |=> state_q == POC_RUN;
  endproperty
  a_low_release: assert property (p_low_release)
    else $error("low mode did not release at low level");

  property p_high_wait;
    @(posedge core_clk) disable iff (!rst_n)
    state_q == POC_WAIT_HIGH && !cmp.poc_above_high |=> state_q != POC_RUN;
  endproperty
  a_high_wait: assert property (p_high_wait)
    else $error("high mode released below the high level");

  property p_fast_stab;
    @(posedge core_clk) disable iff (!rst_n)
    ce && state_q == POC_WAIT_HIGH && cmp.poc_above_low
    && cmp.poc_above_high && cnt_q < FAST_W |=> state_q == POC_STAB;
  endproperty
  a_fast_stab: assert property (p_fast_stab)
    else $error("fast rise skipped the stabilization wait");
endmodule
`default_nettype wire

// file: rtl/pclrc_top.sv
// Notes on behaviour
// - low option: release power-on reset once supply is above low level
// - high option: hold power-on reset until the high comparator trips
// - reset is asserted from power-up until the release condition holds
// - supply below the low level always asserts reset, either mode
// - high mode after a drop releases only at the high level
// - a power-on reset clears the whole reset-cause register
// - watchdog or detector reset sets its own cause flag, no clear
// - high mode, fast rise: insert stabilization wait before release
// - detector compares supply or external input, per control bit 2
// - reset action: reset while below threshold, release when above
// - interrupt action: interrupt on both threshold crossings
// - control bit 0 reads the current below-threshold result
// - detector reset sets reset-cause bit 0
// - software picks one of sixteen detection levels for comparator
`timescale 1ns/10ps
`default_nettype none
module pclrc_top #(
  parameter int unsigned POC_FAST_CYC = pclrc_pkg::POC_FAST_CYC,
  parameter int unsigned POC_STAB_CYC = pclrc_pkg::POC_STAB_CYC
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire logic                          poc_low_cmp_in,
  input  wire logic                          poc_high_cmp_in,
  input  wire logic                          det_below_cmp_in,
  input  wire logic                          poc_threshold_option,
  input  wire logic                          watchdog_timer_reset_req,
  input  wire logic [pclrc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [pclrc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [pclrc_pkg::DATA_W-1:0]  reg_rdata,
  output logic                               internal_reset_n,
  output logic                               detector_enable,
  output logic                               detector_source_select,
  output logic      [pclrc_pkg::LEVEL_W-1:0] detector_level,
  output logic                               irq
);
  import pclrc_pkg::*;

  pclrc_cmp_if cmp ();

  logic                poc_hold;
  logic                poc_clear_q;
  logic                en_q;
  logic                src_q;
  logic                act_q;
  logic [LEVEL_W-1:0]  level_q;
  logic                flag_q;
  logic                flag_d;
  logic                det_rst_q;
  logic                det_rst_d;
  logic                wdt_rst_q;
  logic [DATA_W-1:0]   cause_q;
  logic [DATA_W-1:0]   stat_q;
  logic [DATA_W-1:0]   mask_q;
  logic [DATA_W-1:0]   rdata_d;
  logic [DATA_W-1:0]   cause_set;
  logic [DATA_W-1:0]   stat_set;
  logic [DATA_W-1:0]   stat_clr;
  logic                cross_evt;
  logic                det_rst_set;
  logic                ctl_clear;
  logic                wr_ctrl;
  logic                wr_level;
  logic                wr_stat;
  logic                wr_mask;
  logic                rd_cause;
  logic                irq_q;

  // sticky update where a new event beats a clear in the same cycle
  function automatic logic [DATA_W-1:0] sticky(
    input logic [DATA_W-1:0] cur,
    input logic [DATA_W-1:0] set,
    input logic [DATA_W-1:0] clr
  );
    sticky = (cur & ~clr) | set;
  endfunction

  // strobe qualified by an address match, bus operands passed in
  function automatic logic bus_hit(
    input logic              stb,
    input logic [ADDR_W-1:0] adr,
    input logic [ADDR_W-1:0] want
  );
    bus_hit = stb && (adr == want);
  endfunction

  pclrc_sync u_sync (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .poc_low_raw   (poc_low_cmp_in),
    .poc_high_raw  (poc_high_cmp_in),
    .det_below_raw (det_below_cmp_in),
    .opt_raw       (poc_threshold_option),
    .cmp           (cmp.src)
  );

  pclrc_poc_seq #(
    .FAST_CYC (POC_FAST_CYC),
    .STAB_CYC (POC_STAB_CYC)
  ) u_poc (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .cmp         (cmp.dst),
    .hold        (poc_hold),
    .poc_clear_q (poc_clear_q)
  );

  assign wr_ctrl  = bus_hit(reg_wr, reg_addr, ADR_DET_CTRL);
  assign wr_level = bus_hit(reg_wr, reg_addr, ADR_DET_LEVEL);
  assign wr_stat  = bus_hit(reg_wr, reg_addr, ADR_IRQ_STAT);
  assign wr_mask  = bus_hit(reg_wr, reg_addr, ADR_IRQ_MASK);
  assign rd_cause = bus_hit(reg_rd, reg_addr, ADR_CAUSE);

  // resets other than the detector's wipe the detector setup
  assign ctl_clear = poc_clear_q || wdt_rst_q || poc_hold;

  // detector configuration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q    <= 1'b0;
      src_q   <= 1'b0;
      act_q   <= 1'b0;
    end else if (ce) begin
      if (ctl_clear) begin
        en_q  <= 1'b0;
        src_q <= 1'b0;
        act_q <= 1'b0;
      end else if (wr_ctrl) begin
        en_q  <= reg_wdata[CTL_EN_BIT];
        src_q <= reg_wdata[CTL_SRC_BIT];
        act_q <= reg_wdata[CTL_ACT_BIT];
      end
    end
  end

  // detection level select
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= LEVEL_RST;
    end else if (ce) begin
      if (ctl_clear) begin
        level_q <= LEVEL_RST;
      end else if (wr_level) begin
        level_q <= reg_wdata[LEVEL_W-1:0];
      end
    end
  end

  assign detector_enable        = en_q;
  assign detector_source_select = src_q;
  assign detector_level         = level_q;

  // below-threshold flag, zero while the detector is off
  assign flag_d = en_q && cmp.det_below;
  assign cross_evt = (flag_d != flag_q) && !act_q;
  assign det_rst_d = en_q && act_q && cmp.det_below;
  assign det_rst_set = det_rst_d && !det_rst_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      flag_q <= flag_d;
    end
  end

  // detector reset follows the comparison level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_rst_q <= 1'b0;
    end else if (ce) begin
      det_rst_q <= det_rst_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_rst_q <= 1'b0;
    end else if (ce) begin
      wdt_rst_q <= watchdog_timer_reset_req;
    end
  end

  // drop below the low level asserts reset without a clock
  assign internal_reset_n = poc_low_cmp_in && !poc_hold
                         && !det_rst_q && !wdt_rst_q;

  always_comb begin
    cause_set = 8'h00;
    cause_set[CAUSE_DET_BIT] = det_rst_set;
    cause_set[CAUSE_WDT_BIT] = watchdog_timer_reset_req && !wdt_rst_q;
  end

  // reset cause: cleared by power-on reset or read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= CAUSE_RST;
    end else if (ce) begin
      if (poc_clear_q) begin
        cause_q <= CAUSE_RST;
      end else begin
        cause_q <= sticky(cause_q, cause_set, rd_cause ? 8'hFF : 8'h00);
      end
    end
  end

  always_comb begin
    stat_set = 8'h00;
    stat_set[IRQ_CROSS_BIT] = cross_evt;
    stat_set[IRQ_DRST_BIT]  = det_rst_set;
    stat_clr = wr_stat ? reg_wdata : 8'h00;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= STAT_RST;
    end else if (ce) begin
      stat_q <= sticky(stat_q, stat_set, stat_clr);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RST;
    end else if (ce && wr_mask) begin
      mask_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(sticky(stat_q, stat_set, stat_clr) & mask_q);
    end
  end

  assign irq = irq_q;

  // read mux
  always_comb begin
    rdata_d = READ_ZERO;
    case (reg_addr)
      ADR_DET_CTRL: begin
        rdata_d[CTL_EN_BIT]   = en_q;
        rdata_d[CTL_SRC_BIT]  = src_q;
        rdata_d[CTL_ACT_BIT]  = act_q;
        rdata_d[CTL_FLAG_BIT] = flag_q;
      end
      ADR_DET_LEVEL: rdata_d[LEVEL_W-1:0] = level_q;
      ADR_CAUSE:     rdata_d = cause_q;
      ADR_IRQ_STAT:  rdata_d = stat_q;
      ADR_IRQ_MASK:  rdata_d = mask_q;
      default:       rdata_d = READ_ZERO;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rdata_d : READ_ZERO;
    end
  end

  property p_poc_low_reset;
    @(posedge core_clk) disable iff (!rst_n)
    !poc_low_cmp_in |-> !internal_reset_n;
  endproperty
  a_poc_low_reset: assert property (p_poc_low_reset)
    else $error("reset not asserted with supply below low level");

  property p_hold_reset;
    @(posedge core_clk) disable iff (!rst_n)
    poc_hold |-> !internal_reset_n;
  endproperty
  a_hold_reset: assert property (p_hold_reset)
    else $error("reset released while supervisor holds");

  property p_poc_clears_cause;
    @(posedge core_clk) disable iff (!rst_n)
    ce && poc_clear_q |=> cause_q == CAUSE_RST;
  endproperty
  a_poc_clears_cause: assert property (p_poc_clears_cause)
    else $error("power-on reset left cause bits set");

  property p_det_cause;
    @(posedge core_clk) disable iff (!rst_n)
    ce && det_rst_set && !poc_clear_q |=> cause_q[CAUSE_DET_BIT];
  endproperty
  a_det_cause: assert property (p_det_cause)
    else $error("detector reset did not set its cause bit");

  property p_wdt_cause;
    @(posedge core_clk) disable iff (!rst_n)
    ce && watchdog_timer_reset_req && !wdt_rst_q && !poc_clear_q
    |=> cause_q[CAUSE_WDT_BIT] && !internal_reset_n;
  endproperty
  a_wdt_cause: assert property (p_wdt_cause)
    else $error("watchdog reset did not set its cause bit");

  property p_det_reset;
    @(posedge core_clk) disable iff (!rst_n)
    ce && en_q && act_q && cmp.det_below |=> !internal_reset_n;
  endproperty
  a_det_reset: assert property (p_det_reset)
    else $error("detector reset not asserted below threshold");

  property p_cross_irq;
    @(posedge core_clk) disable iff (!rst_n)
    ce && cross_evt |=> stat_q[IRQ_CROSS_BIT];
  endproperty
  a_cross_irq: assert property (p_cross_irq)
    else $error("threshold crossing lost its status bit");

  property p_flag_read;
    @(posedge core_clk) disable iff (!rst_n)
    ce && reg_rd && reg_addr == ADR_DET_CTRL
    |=> reg_rdata[CTL_FLAG_BIT] == $past(flag_q);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag read does not match comparison result");

  property p_src_sel;
    @(posedge core_clk) disable iff (!rst_n)
    ce && wr_ctrl && !ctl_clear
    |=> detector_source_select == $past(reg_wdata[CTL_SRC_BIT]);
  endproperty
  a_src_sel: assert property (p_src_sel)
    else $error("source select not applied");

  property p_level_sel;
    @(posedge core_clk) disable iff (!rst_n)
    ce && wr_level && !ctl_clear
    |=> detector_level == $past(reg_wdata[LEVEL_W-1:0]);
  endproperty
  a_level_sel: assert property (p_level_sel)
    else $error("detection level not applied");

  property p_irq_mask;
    @(posedge core_clk) disable iff (!rst_n)
    ce && |(stat_q & mask_q) && !wr_stat |=> irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("unmasked status did not raise irq");

  c_det_reset:  cover property (@(posedge core_clk) det_rst_set);
  c_cross:      cover property (@(posedge core_clk) cross_evt && flag_q);
  c_poc_drop:   cover property (@(posedge core_clk) poc_clear_q);
  c_release:    cover property (@(posedge core_clk) $rose(internal_reset_n));
endmodule
`default_nettype wire

// file: bench/pclrc_supply_model.sv
`timescale 1ns/10ps
`default_nettype none
module pclrc_supply_model #(
  parameter logic [12:0] LOW_MV  = 13'h0636,
  parameter logic [12:0] HIGH_MV = 13'h0A8C,
  parameter logic [12:0] TOP_MV  = 13'h1090,
  parameter logic [12:0] STEP_MV = 13'h009B
) (
  input  wire logic [12:0] supply_mv,
  input  wire logic        ext_below,
  input  wire logic        det_on,
  input  wire logic        det_src,
  input  wire logic [3:0]  det_level,
  output logic             poc_low,
  output logic             poc_high,
  output logic             det_below
);
  logic [12:0] thr_mv;
  // level code picks the supply threshold
  assign thr_mv    = TOP_MV - STEP_MV * {9'h000, det_level};
  assign poc_low   = supply_mv >= LOW_MV;
  assign poc_high  = supply_mv >= HIGH_MV;
  // a stopped comparator reports not below
  assign det_below = det_on & (det_src ? ext_below
                                       : (supply_mv < thr_mv));
endmodule
`default_nettype wire

// file: bench/pclrc_test.sv
`timescale 1ns/10ps
`default_nettype none
module pclrc_test;
  import pclrc_pkg::*;
  localparam int FAST  = 20;
  localparam int STAB  = 30;
  localparam int LIMIT = 5000;
  logic                core_clk  = 1'b0;
  logic                rst_n     = 1'b0;
  logic [ADDR_W-1:0]   reg_addr  = '0;
  logic [DATA_W-1:0]   reg_wdata = '0;
  logic                reg_wr    = 1'b0;
  logic                reg_rd    = 1'b0;
  logic                opt       = 1'b0;
  logic                wdt_req   = 1'b0;
  logic                ce        = 1'b1;
  logic                ext_below = 1'b0;
  logic [12:0]         supply_mv = '0;
  logic [15:0]         seed      = 16'h17FB;
  logic [3:0]          lvl;
  logic                poc_low, poc_high, det_below;
  logic [DATA_W-1:0]   reg_rdata;
  logic                internal_reset_n, det_on, det_src, irq;
  logic [LEVEL_W-1:0]  det_level;
  logic [7:0]          rst8;
  int                  error_cnt  = 0;
  int                  num_checks = 0;
  int                  cyc_cnt    = 0;

  assign rst8 = {7'h00, internal_reset_n};

  pclrc_supply_model model (
    .supply_mv (supply_mv),
    .ext_below (ext_below),
    .det_on    (det_on),
    .det_src   (det_src),
    .det_level (det_level),
    .poc_low   (poc_low),
    .poc_high  (poc_high),
    .det_below (det_below)
  );

  pclrc_top #(.POC_FAST_CYC(FAST), .POC_STAB_CYC(STAB)) DUT (
    .core_clk                 (core_clk),
    .rst_n                    (rst_n),
    .ce                       (ce),
    .poc_low_cmp_in           (poc_low),
    .poc_high_cmp_in          (poc_high),
    .det_below_cmp_in         (det_below),
    .poc_threshold_option     (opt),
    .watchdog_timer_reset_req (wdt_req),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .internal_reset_n         (internal_reset_n),
    .detector_enable          (det_on),
    .detector_source_select   (det_src),
    .detector_level           (det_level),
    .irq                      (irq)
  );

  always #2 core_clk = ~core_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [12:0] thr(input logic [3:0] l);
    return 13'h1090 - 13'h009B * {9'h000, l};
  endfunction

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic set_sup(input logic [12:0] v);
    @(posedge core_clk);
    supply_mv <= v;
    #1;
  endtask

  task automatic set_ext(input logic v);
    @(posedge core_clk);
    ext_below <= v;
  endtask

  task automatic wait_rst(input logic v, input int n);
    for (int i = 0; i < n && internal_reset_n !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  // reset from the watchdog stands one cycle per request cycle
  task automatic wdt_pulse();
    @(posedge core_clk);
    wdt_req <= 1'b1;
    @(posedge core_clk);
    wdt_req <= 1'b0;
    #1;
  endtask

  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(6);
    chk(rst8, 8'h00);
    set_sup(13'h07D0);
    wait_rst(1'b1, 10);
    chk(rst8, 8'h01);
    rdchk(ADR_CAUSE, 8'h00);
    rdchk(3'h6, READ_ZERO);
    // a low clock enable drops a write
    @(posedge core_clk);
    ce <= 1'b0;
    wr(ADR_IRQ_MASK, 8'hFF);
    @(posedge core_clk);
    ce <= 1'b1;
    rdchk(ADR_IRQ_MASK, 8'h00);
    // interrupt action over random levels
    wr(ADR_IRQ_MASK, 8'h01);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      lvl  = seed[3:0];
      wr(ADR_DET_LEVEL, {4'h0, lvl});
      wr(ADR_DET_CTRL, 8'h80);
      chk({4'h0, det_level}, {4'h0, lvl});
      set_sup(thr(lvl) - 13'h0064);
      cyc(4);
      rdchk(ADR_DET_CTRL, 8'h81);
      rdchk(ADR_IRQ_STAT, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(ADR_IRQ_STAT, 8'h01);
      cyc(2);
      chk({7'h00, irq}, 8'h00);
      set_sup(13'h1388);
      cyc(4);
      rdchk(ADR_DET_CTRL, 8'h80);
      rdchk(ADR_IRQ_STAT, 8'h01);
      wr(ADR_IRQ_STAT, 8'h01);
    end
    // external source, interrupt masked
    wr(ADR_IRQ_MASK, 8'h00);
    wr(ADR_DET_CTRL, 8'h84);
    set_ext(1'b1);
    cyc(5);
    rdchk(ADR_DET_CTRL, 8'h85);
    chk({7'h00, det_src}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    // reset action follows the comparator both ways
    wr(ADR_DET_CTRL, 8'h86);
    wait_rst(1'b0, 5);
    chk(rst8, 8'h00);
    set_ext(1'b0);
    wait_rst(1'b1, 10);
    chk(rst8, 8'h01);
    rdchk(ADR_DET_CTRL, 8'h86);
    wdt_pulse();
    chk(rst8, 8'h00);
    wait_rst(1'b1, 6);
    rdchk(ADR_CAUSE, 8'h11);
    // supply drop clears cause, asynchronously asserts reset
    wdt_pulse();
    wait_rst(1'b1, 6);
    set_sup(13'h03E8);
    chk(rst8, 8'h00);
    cyc(5);
    set_sup(13'h07D0);
    wait_rst(1'b1, 10);
    chk(rst8, 8'h01);
    rdchk(ADR_CAUSE, 8'h00);
    rdchk(ADR_DET_CTRL, 8'h00);
    // high option, slow rise
    @(posedge core_clk);
    opt <= 1'b1;
    set_sup(13'h03E8);
    cyc(5);
    set_sup(13'h07D0);
    cyc(FAST + 10);
    chk(rst8, 8'h00);
    set_sup(13'h0BB8);
    wait_rst(1'b1, 10);
    chk(rst8, 8'h01);
    // high option, fast rise
    set_sup(13'h03E8);
    cyc(5);
    set_sup(13'h0BB8);
    cyc(STAB);
    chk(rst8, 8'h00);
    wait_rst(1'b1, 20);
    chk(rst8, 8'h01);
    final_report();
  end
endmodule
`default_nettype wire
